// *** shared/conv_regs_pkg.sv ***
// Register map, field positions and reset values of the converter register block
package conv_regs_pkg;

   localparam int unsigned NUM_CHANNELS    = 8;
   localparam int unsigned RESULT_BITS     = 10;
   localparam int unsigned LOW_RES_BITS    = 8;
   localparam int unsigned ADDR_BITS       = 8;
   localparam int unsigned DMA_COUNT_BITS  = 16;

   localparam logic [7:0] OFF_CONTROL            = 8'h00;
   localparam logic [7:0] OFF_MODE               = 8'h04;
   localparam logic [7:0] OFF_CHANNEL_ENABLE_SET = 8'h10;
   localparam logic [7:0] OFF_CHANNEL_ENABLE_CLR = 8'h14;
   localparam logic [7:0] OFF_CHANNEL_STATE      = 8'h18;
   localparam logic [7:0] OFF_STATUS             = 8'h1C;
   localparam logic [7:0] OFF_LAST_RESULT        = 8'h20;
   localparam logic [7:0] OFF_IRQ_ENABLE_SET     = 8'h24;
   localparam logic [7:0] OFF_IRQ_ENABLE_CLR     = 8'h28;
   localparam logic [7:0] OFF_IRQ_ENABLE_VIEW    = 8'h2C;
   localparam logic [7:0] OFF_CHANNEL_RESULT0    = 8'h30;
   localparam logic [7:0] OFF_CHANNEL_RESULT7    = 8'h4C;
   localparam logic [7:0] OFF_DMA_RX_COUNTER     = 8'h50;
   localparam logic [7:0] OFF_DMA_NEXT_RX_COUNTER = 8'h54;

   localparam int unsigned CTRL_SOFT_RESET_POS   = 0;
   localparam int unsigned CTRL_START_POS        = 1;
   localparam int unsigned MODE_RES_SELECT_POS   = 4;

   localparam int unsigned STAT_DONE_LSB         = 0;
   localparam int unsigned STAT_OVERRUN_LSB      = 8;
   localparam int unsigned STAT_READY_POS        = 16;
   localparam int unsigned STAT_GEN_OVERRUN_POS  = 17;
   localparam int unsigned STAT_DMA_ZERO_POS     = 18;
   localparam int unsigned STAT_DMA_BOTH_POS     = 19;
   localparam int unsigned STAT_WIDTH            = 20;

   localparam logic [31:0] MODE_RESET    = 32'h0000_0000;
   localparam logic [31:0] MODE_MASK     = 32'h0FFF_FF3F;
   localparam logic [1:0]  RESP_OKAY     = 2'b00;
   localparam logic [1:0]  RESP_SLVERR   = 2'b10;

   typedef enum logic [1:0]
   {
      BUS_IDLE  = 2'b00,
      BUS_RESP  = 2'b01
   } bus_state_t;

endpackage : conv_regs_pkg

// *** hdl/irq_mask_unit.sv ***
// Interrupt enable set/clear bank with masked interrupt output
module irq_mask_unit
#(
   parameter int unsigned WIDTH = 20
)
(
   input  wire logic             clk,
   input  wire logic             reset_n,
   input  wire logic             soft_reset,
   input  wire logic             set_write,
   input  wire logic             clear_write,
   input  wire logic [WIDTH-1:0] write_bits,
   input  wire logic [WIDTH-1:0] status,
   output logic      [WIDTH-1:0] enable_view,
   output logic                  irq
);

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         enable_view <= '0;
      else if (soft_reset)
         enable_view <= '0;
      else if (set_write)
         enable_view <= enable_view | write_bits;
      else if (clear_write)
         enable_view <= enable_view & ~write_bits;
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         irq <= 1'b0;
      else
         irq <= |(status & enable_view);
   end

endmodule : irq_mask_unit

// *** hdl/channel_result_bank.sv ***
// Per-channel result storage, loaded only for enabled channels
module channel_result_bank
#(
   parameter int unsigned CHANNELS = 8,
   parameter int unsigned BITS     = 10
)
(
   input  wire logic                      clk,
   input  wire logic                      reset_n,
   input  wire logic                      soft_reset,
   input  wire logic                      conv_done,
   input  wire logic [2:0]                conv_channel,
   input  wire logic [BITS-1:0]           conv_data,
   input  wire logic [CHANNELS-1:0]       chan_bit,
   output logic      [CHANNELS-1:0][BITS-1:0] results
);

   genvar g;
   generate
      for (g = 0; g < CHANNELS; g++)
      begin : g_chan
         always_ff @(posedge clk or negedge reset_n)
         begin
            if (!reset_n)
               results[g] <= '0;
            else if (soft_reset)
               results[g] <= '0;
            else if (conv_done && conv_channel == 3'(g) && chan_bit[g])
               results[g] <= conv_data;
         end
      end
   endgenerate

endmodule : channel_result_bank

// *** hdl/conv_status_regs.sv ***
// Converter status, interrupt and result registers behind an AXI4-Lite slave
module conv_status_regs
#(
   parameter int unsigned CHANNELS = conv_regs_pkg::NUM_CHANNELS,
   parameter int unsigned BITS     = conv_regs_pkg::RESULT_BITS
)
(
   input  wire logic                 CLK,
   input  wire logic                 RESET_N,
   // AXI4-Lite slave
   input  wire logic [7:0]           AWADDR,
   input  wire logic                 AWVALID,
   output logic                      AWREADY,
   input  wire logic [31:0]          WDATA,
   input  wire logic [3:0]           WSTRB,
   input  wire logic                 WVALID,
   output logic                      WREADY,
   output logic [1:0]                BRESP,
   output logic                      BVALID,
   input  wire logic                 BREADY,
   input  wire logic [7:0]           ARADDR,
   input  wire logic                 ARVALID,
   output logic                      ARREADY,
   output logic [31:0]               RDATA,
   output logic [1:0]                RRESP,
   output logic                      RVALID,
   input  wire logic                 RREADY,
   // Converter core side
   input  wire logic                 CONV_DONE,
   input  wire logic [2:0]           CONV_CHANNEL,
   input  wire logic [BITS-1:0]      CONV_DATA,
   input  wire logic                 CHAN_OVERRUN,
   input  wire logic                 GENERAL_OVERRUN,
   input  wire logic                 DMA_RX_DECREMENT,
   output logic                      CONV_START,
   output logic                      RESOLUTION_SELECT,
   output logic [CHANNELS-1:0]       CHANNEL_ENABLED,
   output logic                      IRQ
);

   localparam int unsigned SW = conv_regs_pkg::STAT_WIDTH;
   localparam int unsigned CW = conv_regs_pkg::DMA_COUNT_BITS;

   ////////////////////////////////////////////////////////////////////////////////
   // Bus handshake

   logic                        aw_held;
   logic                        w_held;
   logic [7:0]                  aw_addr;
   logic [31:0]                 w_data;
   logic [3:0]                  w_strb;
   conv_regs_pkg::bus_state_t   rd_state;
   logic                        wr_fire;
   logic                        rd_fire;
   logic [7:0]                  rd_addr;
   logic [31:0]                 wr_bits;
   logic                        soft_reset;

   assign wr_fire = aw_held && w_held && !BVALID;
   assign rd_fire = ARVALID && ARREADY;
   assign rd_addr = ARADDR;
   assign wr_bits = w_data & {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};

   function automatic logic wr_hit(input logic [7:0] off);
      wr_hit = wr_fire && aw_addr[7:2] == off[7:2];
   endfunction : wr_hit

   function automatic logic rd_hit(input logic [7:0] off);
      rd_hit = rd_fire && rd_addr[7:2] == off[7:2];
   endfunction : rd_hit

   assign soft_reset = wr_hit(conv_regs_pkg::OFF_CONTROL)
                       && wr_bits[conv_regs_pkg::CTRL_SOFT_RESET_POS];

   always_ff @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         aw_held <= 1'b0;
         aw_addr <= 8'h00;
         AWREADY <= 1'b1;
      end
      else if (AWVALID && AWREADY)
      begin
         aw_held <= 1'b1;
         aw_addr <= AWADDR;
         AWREADY <= 1'b0;
      end
      else if (wr_fire)
      begin
         aw_held <= 1'b0;
         AWREADY <= 1'b1;
      end
   end

   always_ff @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         w_held <= 1'b0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         WREADY <= 1'b1;
      end
      else if (WVALID && WREADY)
      begin
         w_held <= 1'b1;
         w_data <= WDATA;
         w_strb <= WSTRB;
         WREADY <= 1'b0;
      end
      else if (wr_fire)
      begin
         w_held <= 1'b0;
         WREADY <= 1'b1;
      end
   end

   always_ff @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         BVALID <= 1'b0;
         BRESP  <= conv_regs_pkg::RESP_OKAY;
      end
      else if (wr_fire)
      begin
         BVALID <= 1'b1;
         BRESP  <= wr_map(aw_addr) ? conv_regs_pkg::RESP_OKAY : conv_regs_pkg::RESP_SLVERR;
      end
      else if (BREADY)
         BVALID <= 1'b0;
   end

   function automatic logic wr_map(input logic [7:0] a);
      wr_map = a[1:0] == 2'b00 && (a <= conv_regs_pkg::OFF_MODE
               || (a >= conv_regs_pkg::OFF_CHANNEL_ENABLE_SET && a <= conv_regs_pkg::OFF_IRQ_ENABLE_CLR
                   && a != conv_regs_pkg::OFF_CHANNEL_STATE && a != conv_regs_pkg::OFF_STATUS
                   && a != conv_regs_pkg::OFF_LAST_RESULT)
               || a == conv_regs_pkg::OFF_DMA_RX_COUNTER || a == conv_regs_pkg::OFF_DMA_NEXT_RX_COUNTER);
   endfunction : wr_map

   ////////////////////////////////////////////////////////////////////////////////
   // Control and mode

   logic [31:0]         mode;
   logic [CHANNELS-1:0] chan_bit;

   always_ff @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
         CONV_START <= 1'b0;
      else
         CONV_START <= wr_hit(conv_regs_pkg::OFF_CONTROL) && !soft_reset
                       && wr_bits[conv_regs_pkg::CTRL_START_POS];
   end

   always_ff @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
         mode <= conv_regs_pkg::MODE_RESET;
      else if (soft_reset)
         mode <= conv_regs_pkg::MODE_RESET;
      else if (wr_hit(conv_regs_pkg::OFF_MODE))
         mode <= wr_bits & conv_regs_pkg::MODE_MASK;
   end

   assign RESOLUTION_SELECT = mode[conv_regs_pkg::MODE_RES_SELECT_POS];

   always_ff @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
         chan_bit <= '0;
      else if (soft_reset)
         chan_bit <= '0;
      else if (wr_hit(conv_regs_pkg::OFF_CHANNEL_ENABLE_SET))
         chan_bit <= chan_bit | wr_bits[CHANNELS-1:0];
      else if (wr_hit(conv_regs_pkg::OFF_CHANNEL_ENABLE_CLR))
         chan_bit <= chan_bit & ~wr_bits[CHANNELS-1:0];
   end

   assign CHANNEL_ENABLED = chan_bit;

   ////////////////////////////////////////////////////////////////////////////////
   // Conversion results

   logic [BITS-1:0]                 conv_sized;
   logic [BITS-1:0]                 last_result_field;
   logic [CHANNELS-1:0][BITS-1:0]   results;

   // Low resolution keeps the top eight bits of the core result
   assign conv_sized = RESOLUTION_SELECT
                       ? BITS'(CONV_DATA[BITS-1 -: conv_regs_pkg::LOW_RES_BITS])
                       : CONV_DATA;

   always_ff @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
         last_result_field <= '0;
      else if (soft_reset)
         last_result_field <= '0;
      else if (CONV_DONE)
         last_result_field <= conv_sized;
   end

   channel_result_bank #(.CHANNELS(CHANNELS), .BITS(BITS)) u_results
   (
      .clk          (CLK),
      .reset_n      (RESET_N),
      .soft_reset   (soft_reset),
      .conv_done    (CONV_DONE),
      .conv_channel (CONV_CHANNEL),
      .conv_data    (conv_sized),
      .chan_bit     (chan_bit),
      .results      (results)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Status flags; a set in the clearing cycle wins, except the done flags, which a disabled channel holds clear, and the DMA zero flag, where a counter write wins

   logic [CHANNELS-1:0] conv_done_flag;
   logic [CHANNELS-1:0] chan_overrun_flag;
   logic                result_ready_flag;
   logic                general_overrun_flag;
   logic                dma_count_zero_flag;
   logic [CW-1:0]       dma_rx_counter;
   logic [CW-1:0]       dma_next_rx_counter;
   logic [CHANNELS-1:0] done_hit;
   logic                status_read;
   logic                dma_write;

   assign done_hit    = CONV_DONE ? (CHANNELS'(1) << CONV_CHANNEL) : '0;
   assign status_read = rd_hit(conv_regs_pkg::OFF_STATUS);
   assign dma_write   = wr_hit(conv_regs_pkg::OFF_DMA_RX_COUNTER)
                        || wr_hit(conv_regs_pkg::OFF_DMA_NEXT_RX_COUNTER);

   always_ff @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
         conv_done_flag <= '0;
      else if (soft_reset)
         conv_done_flag <= '0;
      else
         conv_done_flag <= (conv_done_flag | done_hit) & chan_bit;
   end

   always_ff @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         chan_overrun_flag    <= '0;
         general_overrun_flag <= 1'b0;
      end
      else if (soft_reset)
      begin
         chan_overrun_flag    <= '0;
         general_overrun_flag <= 1'b0;
      end
      else
      begin
         chan_overrun_flag <= (status_read ? '0 : chan_overrun_flag)
                              | (CHAN_OVERRUN ? done_hit : '0);
         general_overrun_flag <= (general_overrun_flag && !status_read)
                                 || GENERAL_OVERRUN;
      end
   end

   always_ff @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
         result_ready_flag <= 1'b0;
      else if (soft_reset)
         result_ready_flag <= 1'b0;
      else
         result_ready_flag <= (result_ready_flag && !rd_hit(conv_regs_pkg::OFF_LAST_RESULT))
                              || CONV_DONE;
   end

   always_ff @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         dma_rx_counter      <= '0;
         dma_next_rx_counter <= '0;
      end
      else if (soft_reset)
      begin
         dma_rx_counter      <= '0;
         dma_next_rx_counter <= '0;
      end
      else if (wr_hit(conv_regs_pkg::OFF_DMA_RX_COUNTER))
         dma_rx_counter <= wr_bits[CW-1:0];
      else if (wr_hit(conv_regs_pkg::OFF_DMA_NEXT_RX_COUNTER))
         dma_next_rx_counter <= wr_bits[CW-1:0];
      else if (DMA_RX_DECREMENT && dma_rx_counter != '0)
      begin
         // Next buffer takes over when the current one runs out
         if (dma_rx_counter == CW'(1))
         begin
            dma_rx_counter      <= dma_next_rx_counter;
            dma_next_rx_counter <= '0;
         end
         else
            dma_rx_counter <= dma_rx_counter - CW'(1);
      end
   end

   always_ff @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
         dma_count_zero_flag <= 1'b1;
      else if (soft_reset)
         dma_count_zero_flag <= 1'b1;
      else if (DMA_RX_DECREMENT && dma_rx_counter == CW'(1) && !dma_write)
         dma_count_zero_flag <= 1'b1;
      else if (dma_write)
         dma_count_zero_flag <= 1'b0;
   end

   logic [SW-1:0] status;

   assign status = {(dma_rx_counter == '0 && dma_next_rx_counter == '0),
                    dma_count_zero_flag, general_overrun_flag, result_ready_flag,
                    chan_overrun_flag, conv_done_flag};

   ////////////////////////////////////////////////////////////////////////////////
   // Interrupt mask and read data

   logic [SW-1:0] enable_view;

   irq_mask_unit #(.WIDTH(SW)) u_irq
   (
      .clk         (CLK),
      .reset_n     (RESET_N),
      .soft_reset  (soft_reset),
      .set_write   (wr_hit(conv_regs_pkg::OFF_IRQ_ENABLE_SET)),
      .clear_write (wr_hit(conv_regs_pkg::OFF_IRQ_ENABLE_CLR)),
      .write_bits  (wr_bits[SW-1:0]),
      .status      (status),
      .enable_view (enable_view),
      .irq         (IRQ)
   );

   assign ARREADY = (rd_state == conv_regs_pkg::BUS_IDLE);

   always_ff @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         rd_state <= conv_regs_pkg::BUS_IDLE;
         RVALID   <= 1'b0;
         RDATA    <= 32'h0000_0000;
         RRESP    <= conv_regs_pkg::RESP_OKAY;
      end
      else unique case (rd_state)
         conv_regs_pkg::BUS_IDLE:
            if (ARVALID)
            begin
               rd_state <= conv_regs_pkg::BUS_RESP;
               RVALID   <= 1'b1;
               RRESP    <= conv_regs_pkg::RESP_OKAY;
               RDATA    <= 32'h0000_0000;
               if (rd_addr[1:0] != 2'b00)
                  RRESP <= conv_regs_pkg::RESP_SLVERR;
               else if (rd_addr == conv_regs_pkg::OFF_MODE)
                  RDATA <= mode;
               else if (rd_addr == conv_regs_pkg::OFF_CHANNEL_STATE)
                  RDATA <= 32'(chan_bit);
               else if (rd_addr == conv_regs_pkg::OFF_STATUS)
                  RDATA <= 32'(status);
               else if (rd_addr == conv_regs_pkg::OFF_LAST_RESULT)
                  RDATA <= 32'(last_result_field);
               else if (rd_addr == conv_regs_pkg::OFF_IRQ_ENABLE_VIEW)
                  RDATA <= 32'(enable_view);
               else if (rd_addr >= conv_regs_pkg::OFF_CHANNEL_RESULT0
                        && rd_addr <= conv_regs_pkg::OFF_CHANNEL_RESULT7)
                  RDATA <= 32'(results[3'(rd_addr[7:2] - conv_regs_pkg::OFF_CHANNEL_RESULT0[7:2])]);
               else if (rd_addr == conv_regs_pkg::OFF_DMA_RX_COUNTER)
                  RDATA <= 32'(dma_rx_counter);
               else if (rd_addr == conv_regs_pkg::OFF_DMA_NEXT_RX_COUNTER)
                  RDATA <= 32'(dma_next_rx_counter);
               else
                  RRESP <= conv_regs_pkg::RESP_SLVERR;
            end
         conv_regs_pkg::BUS_RESP:
            if (RREADY)
            begin
               rd_state <= conv_regs_pkg::BUS_IDLE;
               RVALID   <= 1'b0;
            end
         default:
            rd_state <= conv_regs_pkg::BUS_IDLE;
      endcase
   end

endmodule : conv_status_regs

// *** tb/conv_status_regs_assertions.sv ***
// Port-level checker for the converter status and result register block
module conv_status_regs_assertions
#(
   parameter int unsigned CHANNELS = 8
)
(
   input wire logic                CLK,
   input wire logic                RESET_N,
   input wire logic [1:0]          BRESP,
   input wire logic                BVALID,
   input wire logic                BREADY,
   input wire logic                ARVALID,
   input wire logic                ARREADY,
   input wire logic [31:0]         RDATA,
   input wire logic                RVALID,
   input wire logic                RREADY,
   input wire logic                CONV_DONE,
   input wire logic                GENERAL_OVERRUN,
   input wire logic                DMA_RX_DECREMENT,
   input wire logic                CONV_START,
   input wire logic                RESOLUTION_SELECT,
   input wire logic [CHANNELS-1:0] CHANNEL_ENABLED,
   input wire logic                IRQ
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RESET_N);
   ////////////////////////////////////////////////////////////////////////////////
   property p_start_pulse; CONV_START |=> !CONV_START; endproperty
   a_start_pulse: assert property (p_start_pulse) else $error("start too long");
   property p_start_write; $rose(CONV_START) |-> $rose(BVALID); endproperty
   a_start_write: assert property (p_start_write) else $error("start no write");
   property p_chan_write; !$stable(CHANNEL_ENABLED) |-> $rose(BVALID); endproperty
   a_chan_write: assert property (p_chan_write) else $error("enable moved");
   property p_res_write; !$stable(RESOLUTION_SELECT) |-> $rose(BVALID); endproperty
   a_res_write: assert property (p_res_write) else $error("mode moved");
   property p_irq_rise;
      $rose(IRQ) |-> $past(CONV_DONE | GENERAL_OVERRUN | DMA_RX_DECREMENT, 2) || $past(BVALID);
   endproperty
   a_irq_rise: assert property (p_irq_rise) else $error("irq rose");
   property p_irq_fall; $fell(IRQ) |-> $past(BVALID || RVALID); endproperty
   a_irq_fall: assert property (p_irq_fall) else $error("irq fell");
   property p_read_answer; ARVALID && ARREADY |=> RVALID; endproperty
   a_read_answer: assert property (p_read_answer) else $error("read late");
   property p_read_hold; RVALID && !RREADY |=> RVALID && $stable(RDATA); endproperty
   a_read_hold: assert property (p_read_hold) else $error("rdata moved");
   property p_write_hold; BVALID && !BREADY |=> BVALID && $stable(BRESP); endproperty
   a_write_hold: assert property (p_write_hold) else $error("bresp moved");
endmodule : conv_status_regs_assertions

bind conv_status_regs conv_status_regs_assertions #(.CHANNELS(CHANNELS)) u_chk
(
   .CLK, .RESET_N, .BRESP, .BVALID, .BREADY, .ARVALID, .ARREADY, .RDATA, .RVALID, .RREADY,
   .CONV_DONE, .GENERAL_OVERRUN, .DMA_RX_DECREMENT, .CONV_START, .RESOLUTION_SELECT,
   .CHANNEL_ENABLED, .IRQ
);

// *** tb/conv_core_model.sv ***
// Behavioural converter core driving conversion, overrun and DMA events
module conv_core_model
(
   input  wire logic       clk,
   input  wire logic       reset_n,
   input  wire logic       req, ovr, govr, dec,
   input  wire logic [2:0] ch,
   input  wire logic [9:0] data,
   output logic            conv_done, chan_overrun, general_overrun, dma_rx_decrement,
   output logic [2:0]      conv_channel,
   output logic [9:0]      conv_data
);
   timeunit 1ns;
   timeprecision 1ns;
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         conv_done <= 1'b0;
         chan_overrun <= 1'b0;
         general_overrun <= 1'b0;
         dma_rx_decrement <= 1'b0;
         conv_channel <= 3'h0;
         conv_data <= 10'h000;
      end
      else
      begin
         conv_done <= req;
         chan_overrun <= req & ovr;
         general_overrun <= govr;
         dma_rx_decrement <= dec;
         // Unqualified lines toggle rather than hold
         conv_channel <= req ? ch : ~conv_channel;
         conv_data <= req ? data : ~conv_data;
      end
   end
endmodule : conv_core_model

// *** tb/tb_top.sv ***
// Self-checking bench for the converter status and result register block
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {logic [31:0] d; logic [1:0] r; string n;} exp_t;
   logic        CLK = 1'b0, RESET_N = 1'b0;
   logic [7:0]  AWADDR = 8'h00, ARADDR = 8'h00, CHANNEL_ENABLED;
   logic [31:0] WDATA = 32'h0000_0000, RDATA, seed = 32'h0001_68E2;
   logic [31:0] res [8];
   logic [3:0]  WSTRB = 4'hF;
   logic        AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
   logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, CONV_START, RESOLUTION_SELECT, IRQ;
   logic        CONV_DONE, CHAN_OVERRUN, GENERAL_OVERRUN, DMA_RX_DECREMENT;
   logic        req = 1'b0, ovr = 1'b0, govr = 1'b0, dec = 1'b0;
   logic [1:0]  BRESP, RRESP;
   logic [2:0]  CONV_CHANNEL, ch = 3'h0;
   logic [9:0]  CONV_DATA, data = 10'h000, d;
   int          miscompares = 0, checked = 0, cycles = 0, starts = 0;
   exp_t        rq[$], ex;
   logic [1:0]  bq[$];

   conv_status_regs u_conv_status_regs
   (
      .CLK, .RESET_N, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID, .WREADY, .BRESP,
      .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY,
      .CONV_DONE, .CONV_CHANNEL, .CONV_DATA, .CHAN_OVERRUN, .GENERAL_OVERRUN,
      .DMA_RX_DECREMENT, .CONV_START, .RESOLUTION_SELECT, .CHANNEL_ENABLED, .IRQ
   );
   conv_core_model u_conv_core_model
   (
      .clk(CLK), .reset_n(RESET_N), .req, .ovr, .govr, .dec, .ch, .data,
      .conv_done(CONV_DONE), .chan_overrun(CHAN_OVERRUN),
      .general_overrun(GENERAL_OVERRUN), .dma_rx_decrement(DMA_RX_DECREMENT),
      .conv_channel(CONV_CHANNEL), .conv_data(CONV_DATA)
   );
   ////////////////////////////////////////////////////////////////////////////////
   always #25 CLK = ~CLK;

   function automatic logic [9:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[9:0];
   endfunction : rnd

   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e)
      begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask : chk

   task stop_test();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : stop_test

   task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] r = 2'b00);
      logic aw = 1'b1;
      logic w = 1'b1;
      bq.push_back(r);
      @(posedge CLK);
      AWADDR <= a;
      WDATA <= v;
      AWVALID <= 1'b1;
      WVALID <= 1'b1;
      BREADY <= 1'b1;
      while (aw || w)
      begin
         @(posedge CLK);
         if (AWREADY) aw = 1'b0;
         if (WREADY) w = 1'b0;
         AWVALID <= aw;
         WVALID <= w;
      end
      do @(posedge CLK); while (!BVALID);
      BREADY <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n,
                     input logic [1:0] r = 2'b00);
      rq.push_back(exp_t'{e, r, n});
      @(posedge CLK);
      ARADDR <= a;
      ARVALID <= 1'b1;
      RREADY <= 1'b1;
      do @(posedge CLK); while (!ARREADY);
      ARVALID <= 1'b0;
      do @(posedge CLK); while (!RVALID);
      RREADY <= 1'b0;
   endtask : rd

   task automatic ev(input logic [2:0] c, input logic r, o, g, k);
      d = rnd();
      @(posedge CLK);
      req <= r;
      ch <= c;
      data <= d;
      ovr <= o;
      govr <= g;
      dec <= k;
      @(posedge CLK);
      req <= 1'b0;
      govr <= 1'b0;
      dec <= 1'b0;
      repeat (3) @(posedge CLK);
   endtask : ev
   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge CLK)
   begin
      if (RVALID && RREADY && rq.size() > 0)
      begin
         ex = rq.pop_front();
         chk({ex.n, " resp"}, 32'(RRESP), 32'(ex.r));
         if (ex.r == 2'b00) chk(ex.n, RDATA, ex.d);
      end
      if (BVALID && BREADY && bq.size() > 0) chk("write resp", 32'(BRESP), 32'(bq.pop_front()));
      if (CONV_START === 1'b1) starts++;
      cycles++;
      if (cycles == 20000)
      begin
         miscompares++;
         stop_test();
      end
   end

   initial
   begin
      repeat (4) @(posedge CLK);
      RESET_N <= 1'b1;
      rd(8'h1C, 32'h000C_0000, "status");
      rd(8'h2C, 32'h0000_0000, "irq view");
      wr(8'h10, 32'h0000_00A7);
      wr(8'h14, 32'h0000_0003);
      wr(8'h14, 32'h0000_0000);
      chk("enabled", {24'h0, CHANNEL_ENABLED}, 32'h0000_00A4);
      rd(8'h18, 32'h0000_00A4, "chan state");
      for (int c = 0; c < 8; c++)
      begin
         ev(3'(c), 1'b1, 1'b0, 1'b0, 1'b0);
         res[c] = (c inside {2, 5, 7}) ? {22'h0, d} : 32'h0000_0000;
      end
      rd(8'h1C, 32'h000D_00A4, "status");
      rd(8'h20, {22'h0, d}, "last result");
      rd(8'h1C, 32'h000C_00A4, "status");
      for (int c = 0; c < 8; c++) rd(8'h30 + 8'(4 * c), res[c], "chan result");
      ev(3'h5, 1'b1, 1'b1, 1'b0, 1'b0);
      rd(8'h1C, 32'h000D_20A4, "status");
      rd(8'h1C, 32'h000D_00A4, "status");
      ev(3'h0, 1'b0, 1'b0, 1'b1, 1'b0);
      rd(8'h1C, 32'h000F_00A4, "status");
      rd(8'h1C, 32'h000D_00A4, "status");
      wr(8'h24, 32'h0002_0000);
      rd(8'h2C, 32'h0002_0000, "irq view");
      chk("irq", {31'h0, IRQ}, 32'h0000_0000);
      ev(3'h0, 1'b0, 1'b0, 1'b1, 1'b0);
      chk("irq", {31'h0, IRQ}, 32'h0000_0001);
      wr(8'h28, 32'h0000_0000);
      chk("irq", {31'h0, IRQ}, 32'h0000_0001);
      wr(8'h24, 32'h000F_FFFF);
      rd(8'h2C, 32'h000F_FFFF, "irq view");
      wr(8'h28, 32'hFFFF_FFFF);
      repeat (2) @(posedge CLK);
      chk("irq", {31'h0, IRQ}, 32'h0000_0000);
      rd(8'h2C, 32'h0000_0000, "irq view");
      wr(8'h50, 32'h0000_0002);
      wr(8'h54, 32'h0000_0000);
      rd(8'h1C, 32'h0003_00A4, "status");
      ev(3'h0, 1'b0, 1'b0, 1'b0, 1'b1);
      ev(3'h0, 1'b0, 1'b0, 1'b0, 1'b1);
      rd(8'h1C, 32'h000D_00A4, "status");
      wr(8'h54, 32'h0000_0001);
      rd(8'h1C, 32'h0001_00A4, "status");
      wr(8'h04, 32'hFFFF_FFFF);
      chk("resolution", {31'h0, RESOLUTION_SELECT}, 32'h0000_0001);
      rd(8'h04, 32'h0FFF_FF3F, "mode");
      ev(3'h7, 1'b1, 1'b0, 1'b0, 1'b0);
      rd(8'h4C, {24'h0, d[9:2]}, "chan result");
      wr(8'h00, 32'h0000_0002);
      @(posedge CLK);
      chk("starts", 32'(starts), 32'h0000_0001);
      wr(8'h00, 32'h0000_0000);
      wr(8'h00, 32'h0000_0003);
      @(posedge CLK);
      chk("starts", 32'(starts), 32'h0000_0001);
      chk("enabled", {24'h0, CHANNEL_ENABLED}, 32'h0000_0000);
      rd(8'h1C, 32'h000C_0000, "status");
      rd(8'h4C, 32'h0000_0000, "chan result");
      rd(8'h08, 32'h0000_0000, "reserved", 2'b10);
      rd(8'h24, 32'h0000_0000, "write only", 2'b10);
      wr(8'h18, 32'h0000_00FF, 2'b10);
      rd(8'h18, 32'h0000_0000, "chan state");
      stop_test();
   end
endmodule : tb_top
